// ---- core/hbcc_pkg.sv ----
// Constants, encodings and types shared by the H-bridge control logic
package hbcc_pkg;
  localparam int CLK_MHZ = 20;
  localparam int OFF_TIME_SELECT_STEP_US = 20;
  localparam int OFF_TIME_SELECT_STEP_CYC = OFF_TIME_SELECT_STEP_US * CLK_MHZ;
  localparam int BLANK_NS = 2000;
  localparam int BLANK_CYC_RAW = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_CYC = (BLANK_CYC_RAW < 1) ? 1 : BLANK_CYC_RAW;
  localparam int CNT_W = 11;
  localparam int AW = 2;
  localparam int DW = 8;
  localparam logic [AW-1:0] ADDR_CW3 = 2'h0;
  localparam logic [AW-1:0] ADDR_CW4 = 2'h1;
  localparam logic [AW-1:0] ADDR_STAT = 2'h2;
  localparam int CW3_MODE_LSB = 0;
  localparam int CW3_FLOAT_A = 2;
  localparam int CW3_FLOAT_B = 3;
  localparam int CW3_OC_CLEAR = 4;
  localparam int CW4_TRIP_LSB = 0;
  localparam int CW4_OFF_TIME_SELECT_LSB = 2;
  localparam int CW4_RDIS_LSB = 4;
  localparam int CW4_OCP_RESP = 6;
  localparam logic [1:0] MODE_RST = 2'h1;
  localparam logic [1:0] TRIP_RST = 2'h0;
  localparam logic [1:0] OFF_TIME_SELECT_RST = 2'h1;
  localparam logic [1:0] RDIS_RST = 2'h0;
  localparam logic [1:0] PIN_TRIP_LVL = 2'h2;
  localparam logic [1:0] PIN_OFF_TIME_SELECT = 2'h1;
  typedef enum logic [1:0] {
    MODE_PHEN = 2'h0,
    MODE_PWM = 2'h1,
    MODE_INDEP = 2'h2,
    MODE_OFF = 2'h3
  } hbcc_mode_t;
  typedef enum logic [2:0] {
    CH_BLANK = 3'b001,
    CH_ARMED = 3'b010,
    CH_OFF = 3'b100
  } hbcc_chop_st_t;
endpackage

// ---- core/hbcc_chop_if.sv ----
// Link between the bridge logic and one current chopper
`timescale 1ns/1ps
interface hbcc_chop_if import hbcc_pkg::*; ();
  logic run;
  logic trip;
  logic regulate_en;
  logic [CNT_W-1:0] off_cyc;
  logic off_active;
  modport ctl (output run, output trip, output regulate_en, output off_cyc, input off_active);
  modport chop (input run, input trip, input regulate_en, input off_cyc, output off_active);
endinterface

// ---- core/hbcc_chop.sv ----
// Fixed off-time current chopper for one half-bridge
`timescale 1ns/1ps
module hbcc_chop
  import hbcc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  hbcc_chop_if.chop cif
);
  hbcc_chop_st_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  wire blank_done = (cnt_q == CNT_W'(BLANK_CYC - 1));
  // At-or-past, so a shorter setting written mid off time cannot wrap the counter
  wire off_done = (cnt_q >= cif.off_cyc - CNT_W'(1));

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + CNT_W'(1);
    if (!cif.run) begin
      st_d = CH_BLANK;
      cnt_d = '0;
    end else begin
      unique case (st_q)
        CH_BLANK: begin
          if (blank_done) begin
            st_d = CH_ARMED;
            cnt_d = '0;
          end
        end
        CH_ARMED: begin
          cnt_d = '0;
          if (cif.regulate_en && cif.trip) begin
            st_d = CH_OFF;
          end
        end
        CH_OFF: begin
          if (!cif.regulate_en) begin
            st_d = CH_BLANK;
            cnt_d = '0;
          end else if (off_done) begin
            st_d = cif.trip ? CH_OFF : CH_BLANK;
            cnt_d = '0;
          end
        end
        default: begin
          st_d = CH_BLANK;
          cnt_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= CH_BLANK;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign cif.off_active = (st_q == CH_OFF);

  AST_CHOP_TRIP: assert property (@(posedge clk) disable iff (!rstn)
    st_q == CH_ARMED && cif.run && cif.regulate_en && cif.trip |=> st_q == CH_OFF)
    else $error("trip while armed did not start off time");
  AST_CHOP_BLANK: assert property (@(posedge clk) disable iff (!rstn)
    st_q == CH_BLANK |=> st_q != CH_OFF)
    else $error("trip acted during blanking");
  AST_CHOP_REPEAT: assert property (@(posedge clk) disable iff (!rstn)
    st_q == CH_OFF && cif.run && cif.regulate_en && off_done
    |=> (st_q == CH_OFF && cnt_q == 0) == $past(cif.trip))
    else $error("off time end did not follow trip level");
  AST_CHOP_LEN: assert property (@(posedge clk) disable iff (!rstn)
    st_q == CH_OFF && cif.run |-> cnt_q < cif.off_cyc)
    else $error("off time overran its setting");
endmodule // hbcc_chop

// ---- core/hbcc_bridge.sv ----
// H-bridge input decode, output float control and current regulation
//
// Function
// - Independent mode floats both outputs in sleep or disable, else each follows input.
// - Independent mode float bit of one half floats only that output.
// - Both float bits reset to zero so outputs follow inputs.
// - Two-bit trip level picks threshold, 00b lowest, rising to 11b.
// - Regulation is active on both halves right after reset.
// - Regulation disable field: 01b half A, 10b half B, 11b both.
// - Pin variant: strap high disables regulation; otherwise fixed trip level.
// - Trip reached forces slow decay for off time: both high sides on, only the tripped half's in independent mode.
// - Off time field selects 20, 40, 60 or 80 microseconds.
// - Off time resets to 40 microseconds; pin variant always 40.
// - Off time end resumes drive if below trip, else another off period.
// - Trip detection ignored during blanking after every return to drive.
// - Overcurrent: pin variant disables outputs; register variant per response field.
// - Mode field: phase/enable, PWM default, independent, or bridge floating.
// - Selected mode is latched when disable falls from high to low.
// - Phase/enable truth table: enable low brakes high, phase picks direction.
// - Independent mode overcurrent disables only the faulting half.
`timescale 1ns/1ps
module hbcc_bridge
  import hbcc_pkg::*;
#(
  parameter bit PIN_VARIANT = 1'b0
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  input wire logic sleep_request_low,
  input wire logic disable_in,
  input wire logic bridge_input_a,
  input wire logic bridge_input_b,
  input wire logic trip_flag_a,
  input wire logic trip_flag_b,
  input wire logic overcurrent_flag_a,
  input wire logic overcurrent_flag_b,
  input wire logic regulation_disable_strap,
  output logic [1:0] trip_level_select,
  output logic half_bridge_a_output,
  output logic half_bridge_a_oe,
  output logic half_bridge_b_output,
  output logic half_bridge_b_oe
);
  localparam int NSYNC = 9;
  if (DW < 8) begin : g_chk
    $error("register width too small for the fields");
  end

  // Pin synchroniser; a change counts once stages two and three agree
  logic [NSYNC-1:0] s1_q, s2_q, s3_q, pin_q;
  wire [NSYNC-1:0] raw = {regulation_disable_strap, overcurrent_flag_b, overcurrent_flag_a,
                          trip_flag_b, trip_flag_a, bridge_input_b, bridge_input_a,
                          disable_in, sleep_request_low};
  wire [NSYNC-1:0] agree = ~(s2_q ^ s3_q);
  wire [NSYNC-1:0] pin_d = (agree & s3_q) | (~agree & pin_q);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end
  wire awake = pin_q[0];
  wire dis = pin_q[1];
  wire in_a = pin_q[2];
  wire in_b = pin_q[3];
  wire [1:0] trip = pin_q[5:4];
  wire [1:0] oc_raw = pin_q[7:6];
  wire strap = pin_q[8];

  // Register file
  logic [4:0] cw3_q;
  logic [6:0] cw4_q;
  wire wr_cw3 = reg_wr && (reg_addr == ADDR_CW3);
  wire wr_cw4 = reg_wr && (reg_addr == ADDR_CW4);
  wire oc_clear = wr_cw3 && reg_wdata[CW3_OC_CLEAR];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cw3_q <= {1'b0, 1'b0, 1'b0, MODE_RST};
      cw4_q <= {1'b0, RDIS_RST, OFF_TIME_SELECT_RST, TRIP_RST};
    end else begin
      if (wr_cw3) begin
        cw3_q <= {1'b0, reg_wdata[CW3_FLOAT_B:CW3_MODE_LSB]};
      end
      if (wr_cw4) begin
        cw4_q <= reg_wdata[CW4_OCP_RESP:CW4_TRIP_LSB];
      end
    end
  end
  wire [1:0] lvl_sel = PIN_VARIANT ? PIN_TRIP_LVL : cw4_q[CW4_TRIP_LSB +: 2];
  wire [1:0] off_time_select_sel = PIN_VARIANT ? PIN_OFF_TIME_SELECT : cw4_q[CW4_OFF_TIME_SELECT_LSB +: 2];
  wire [1:0] rdis = PIN_VARIANT ? {strap, strap} : cw4_q[CW4_RDIS_LSB +: 2];
  wire oc_auto = !PIN_VARIANT && cw4_q[CW4_OCP_RESP];
  wire [1:0] float_bit = PIN_VARIANT ? 2'b00 : cw3_q[CW3_FLOAT_B:CW3_FLOAT_A];
  wire [CNT_W-1:0] off_cyc = CNT_W'((32'(off_time_select_sel) + 32'd1) * OFF_TIME_SELECT_STEP_CYC);

  // Mode latch on the falling edge of disable
  logic dis_prev_q;
  hbcc_mode_t mode_q;
  wire dis_fall = dis_prev_q && !dis;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dis_prev_q <= 1'b0;
      mode_q <= MODE_PWM;
    end else begin
      dis_prev_q <= dis;
      if (dis_fall) begin
        mode_q <= hbcc_mode_t'(cw3_q[CW3_MODE_LSB +: 2]);
      end
    end
  end

  // Overcurrent latch; a new event wins over a clear, sleep releases it
  logic [1:0] oc_lat_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oc_lat_q <= 2'b00;
    end else if (!awake) begin
      oc_lat_q <= 2'b00;
    end else begin
      oc_lat_q <= oc_raw | (oc_lat_q & {2{!oc_clear}});
    end
  end
  wire [1:0] oc_half = oc_auto ? oc_raw : (oc_raw | oc_lat_q);
  wire indep = (mode_q == MODE_INDEP);
  wire [1:0] oc_off = indep ? oc_half : {2{|oc_half}};

  // Base decode from the inputs
  wire en_ok = awake && !dis && (mode_q != MODE_OFF);
  logic [1:0] base_lvl, base_oe;
  always_comb begin
    base_lvl = 2'b00;
    base_oe = 2'b00;
    unique case (mode_q)
      MODE_PHEN: begin
        base_oe = 2'b11;
        base_lvl = !in_a ? 2'b11 : (in_b ? 2'b01 : 2'b10);
      end
      MODE_PWM: begin
        base_oe = {2{in_a | in_b}};
        base_lvl = {in_b, in_a};
      end
      MODE_INDEP: begin
        base_oe = ~float_bit;
        base_lvl = {in_b, in_a};
      end
      MODE_OFF: begin
        base_oe = 2'b00;
        base_lvl = 2'b00;
      end
    endcase
  end

  // One chopper per half
  logic [1:0] off_act;
  hbcc_chop_if cif [2] ();
  for (genvar i = 0; i < 2; i++) begin : g_half
    assign cif[i].run = en_ok && base_oe[i] && !oc_off[i];
    assign cif[i].trip = trip[i];
    assign cif[i].regulate_en = !rdis[i];
    assign cif[i].off_cyc = off_cyc;
    assign off_act[i] = cif[i].off_active;
    hbcc_chop u_chop (
      .clk(clk),
      .rstn(rstn),
      .cif(cif[i])
    );
  end

  // Slow decay forces high sides on; independent mode acts per half
  wire [1:0] decay = indep ? off_act : {2{|off_act}};
  wire [1:0] oe_d = {2{en_ok}} & (base_oe | decay) & ~oc_off;
  wire [1:0] lvl_d = oe_d & (base_lvl | decay);

  logic [1:0] oe_q, lvl_q, lvl_sel_q;
  logic [DW-1:0] rdata_q;
  wire [DW-1:0] rd_mux = (reg_addr == ADDR_CW3) ? DW'(cw3_q) :
                         (reg_addr == ADDR_CW4) ? DW'(cw4_q) :
                         (reg_addr == ADDR_STAT) ? DW'({awake, oc_lat_q, off_act, mode_q}) :
                         '0;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oe_q <= 2'b00;
      lvl_q <= 2'b00;
      lvl_sel_q <= TRIP_RST;
      rdata_q <= '0;
    end else begin
      oe_q <= oe_d;
      lvl_q <= lvl_d;
      lvl_sel_q <= lvl_sel;
      rdata_q <= reg_rd ? rd_mux : '0;
    end
  end
  assign reg_rdata = rdata_q;
  assign trip_level_select = lvl_sel_q;
  assign half_bridge_a_output = lvl_q[0];
  assign half_bridge_a_oe = oe_q[0];
  assign half_bridge_b_output = lvl_q[1];
  assign half_bridge_b_oe = oe_q[1];

  AST_SLEEP_FLOAT: assert property (@(posedge clk) disable iff (!rstn)
    !awake || dis |=> !half_bridge_a_oe && !half_bridge_b_oe)
    else $error("outputs driven in sleep or disable");
  AST_INDEP_FLOAT: assert property (@(posedge clk) disable iff (!rstn)
    indep && float_bit[0] && !off_act[0] |=> !half_bridge_a_oe)
    else $error("half A not floated by its bit");
  AST_RESET_VAL: assert property (@(posedge clk)
    $rose(rstn) |-> cw3_q[3:2] == 2'b00 && cw4_q[5:2] == 4'b0001)
    else $error("register reset values wrong");
  AST_LVL_OUT: assert property (@(posedge clk) disable iff (!rstn)
    wr_cw4 |=> ##1 PIN_VARIANT || trip_level_select == $past(reg_wdata[1:0], 2))
    else $error("trip level select not forwarded");
  AST_MODE_LATCH: assert property (@(posedge clk) disable iff (!rstn)
    dis_fall |=> mode_q == $past(cw3_q[1:0]))
    else $error("mode not latched on disable fall");
  AST_PHEN_BRAKE: assert property (@(posedge clk) disable iff (!rstn)
    en_ok && mode_q == MODE_PHEN && !in_a && oc_off == 2'b00
    |=> half_bridge_a_output && half_bridge_b_output && half_bridge_a_oe && half_bridge_b_oe)
    else $error("enable low did not brake high");
  AST_PWM_COAST: assert property (@(posedge clk) disable iff (!rstn)
    mode_q == MODE_PWM && !in_a && !in_b && off_act == 2'b00
    |=> !half_bridge_a_oe && !half_bridge_b_oe)
    else $error("PWM 00 did not float");
  AST_SLOW_DECAY: assert property (@(posedge clk) disable iff (!rstn)
    en_ok && !indep && off_act != 2'b00 && oc_off == 2'b00
    |=> half_bridge_a_output && half_bridge_b_output)
    else $error("slow decay not enforced");
  AST_OC_PER_HALF: assert property (@(posedge clk) disable iff (!rstn)
    en_ok && indep && oc_half == 2'b01 && !float_bit[1]
    |=> !half_bridge_a_oe && half_bridge_b_oe)
    else $error("independent overcurrent not per half");
endmodule // hbcc_bridge

// ---- verif/hbcc_host_model.sv ----
// Host controller model driving the two bridge inputs
`timescale 1ns/1ps
module hbcc_host_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic want_a,
  input wire logic want_b,
  input wire logic drive_brake,
  output logic bridge_input_a,
  output logic bridge_input_b
);
  logic [5:0] phase_q;
  // Alternates drive and brake (both high) so current recirculates
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= 6'h00;
      bridge_input_a <= 1'b0;
      bridge_input_b <= 1'b0;
    end else begin
      phase_q <= phase_q + 6'h01;
      bridge_input_a <= want_a | (drive_brake & phase_q[5]);
      bridge_input_b <= want_b | (drive_brake & phase_q[5]);
    end
  end
endmodule // hbcc_host_model

// ---- verif/testbench.sv ----
// Self-checking bench for the H-bridge control block
`timescale 1ns/1ps
module testbench;
  import hbcc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [AW-1:0] reg_addr = 2'h0;
  logic [DW-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DW-1:0] reg_rdata;
  logic sleep_n = 1'b1;
  logic disable_in = 1'b0;
  logic want_a = 1'b0;
  logic want_b = 1'b0;
  logic drive_brake = 1'b0;
  logic in_a, in_b;
  logic trip_a = 1'b0;
  logic trip_b = 1'b0;
  logic oc_a = 1'b0;
  logic oc_b = 1'b0;
  logic [1:0] trip_lvl;
  logic a_out, a_oe, b_out, b_oe;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  // Drive level only counts while the half is enabled
  wire logic [3:0] seen = {a_oe, a_oe & a_out, b_oe, b_oe & b_out};

  hbcc_bridge #(.PIN_VARIANT(1'b0)) hbcc_bridge_inst (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_request_low(sleep_n), .disable_in(disable_in),
    .bridge_input_a(in_a), .bridge_input_b(in_b), .trip_flag_a(trip_a),
    .trip_flag_b(trip_b), .overcurrent_flag_a(oc_a), .overcurrent_flag_b(oc_b),
    .regulation_disable_strap(1'b0), .trip_level_select(trip_lvl),
    .half_bridge_a_output(a_out), .half_bridge_a_oe(a_oe),
    .half_bridge_b_output(b_out), .half_bridge_b_oe(b_oe));
  hbcc_host_model hbcc_host_model_inst (.clk(clk), .rstn(rstn), .want_a(want_a),
    .want_b(want_b), .drive_brake(drive_brake), .bridge_input_a(in_a),
    .bridge_input_b(in_b));

  always #25 clk = ~clk;

  task automatic results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      results();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_check(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic wait_seen(input logic [3:0] exp, input int limit, output int n);
    n = 0;
    while (seen !== exp && n < limit) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic pins(input logic a, input logic b);
    @(posedge clk);
    want_a <= a;
    want_b <= b;
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    rd_check(ADDR_CW3, 8'h01);
    rd_check(ADDR_CW4, 8'h04);
    wr(2'h3, 8'hff);
    rd_check(2'h3, 8'h00);
    check({6'h00, trip_lvl}, 8'h00);
  endtask
  task automatic t_mode(input logic [1:0] m, input logic [15:0] exp);
    wr(ADDR_CW3, {6'h00, m});
    @(posedge clk);
    disable_in <= 1'b1;
    repeat (6) @(posedge clk);
    disable_in <= 1'b0;
    repeat (10) @(posedge clk);
    rd_check(ADDR_STAT, {6'h10, m});
    for (int i = 0; i < 4; i++) begin
      pins(i[1], i[0]);
      check({4'h0, seen}, {4'h0, exp[4*i +: 4]});
    end
  endtask
  task automatic t_float();
    wr(ADDR_CW3, 8'h06);
    pins(1'b1, 1'b1);
    check({4'h0, seen}, 8'h03);
    wr(ADDR_CW3, 8'h0a);
    pins(1'b1, 1'b1);
    check({4'h0, seen}, 8'h0c);
    wr(ADDR_CW3, 8'h02);
    disable_in <= 1'b1;
    pins(1'b1, 1'b1);
    check({4'h0, seen}, 8'h00);
    disable_in <= 1'b0;
  endtask
  // Off time measured from the first both-high cycle, tolerating sync latency
  task automatic t_off(input logic [7:0] v, input int hold, input int exp);
    int n;
    wr(ADDR_CW4, v);
    pins(1'b1, 1'b0);
    check({4'h0, seen}, 8'h0e);
    trip_a <= 1'b1;
    // Limit covers a blanking interval still running from the last off period
    wait_seen(4'hf, 100, n);
    for (n = 0; seen === 4'hf && n < 2000; n++) begin
      @(posedge clk);
      if (n == hold) trip_a <= 1'b0;
      #1;
    end
    check({7'h0, n >= exp - 6 && n <= exp + 6}, 8'h01);
  endtask
  task automatic t_blank();
    int n;
    @(posedge clk);
    trip_a <= 1'b1;
    wait_seen(4'hf, 200, n);
    check({7'h0, n >= BLANK_CYC - 6 && n <= BLANK_CYC + 8}, 8'h01);
    pins(1'b0, 1'b1);
    check({4'h0, seen}, 8'h0f);
    trip_a <= 1'b0;
    wait_seen(4'hb, 2000, n);
    check({7'h0, n < 2000}, 8'h01);
  endtask
  task automatic t_oc();
    @(posedge clk);
    oc_a <= 1'b1;
    pins(1'b1, 1'b1);
    check({4'h0, seen}, 8'h03);
    @(posedge clk);
    oc_a <= 1'b0;
    pins(1'b1, 1'b1);
    check({4'h0, seen}, 8'h03);
    rd_check(ADDR_STAT, 8'h52);
    wr(ADDR_CW3, 8'h12);
    pins(1'b1, 1'b1);
    check({4'h0, seen}, 8'h0f);
    wr(ADDR_CW4, 8'h44);
    oc_b <= 1'b1;
    pins(1'b1, 1'b1);
    check({4'h0, seen}, 8'h0c);
    oc_b <= 1'b0;
    pins(1'b1, 1'b1);
    check({4'h0, seen}, 8'h0f);
    // Latch records events even when following the flag; clear it before later status reads
    wr(ADDR_CW3, 8'h12);
    wr(ADDR_CW4, 8'h04);
  endtask
  task automatic t_rdis();
    int n;
    for (int c = 1; c < 4; c++) begin
      for (int j = 0; j < 2; j++) begin
        wr(ADDR_CW4, {2'h0, c[1:0], 4'h0});
        pins(j == 0, j == 1);
        if (j == 0) trip_a <= 1'b1;
        else trip_b <= 1'b1;
        wait_seen(4'hf, 100, n);
        check({7'h0, n < 100}, {7'h0, !c[j]});
        trip_a <= 1'b0;
        trip_b <= 1'b0;
        wait_seen((j == 0) ? 4'he : 4'hb, 2000, n);
      end
    end
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_mode(MODE_PHEN, 16'hebff);
    t_mode(MODE_OFF, 16'h0000);
    t_mode(MODE_INDEP, 16'hfeba);
    t_float();
    t_oc();
    t_mode(MODE_PWM, 16'hfeb0);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CW4, {6'h00, i[1:0]});
      repeat (2) @(posedge clk);
      check({6'h00, trip_lvl}, {6'h00, i[1:0]});
    end
    t_off(8'h04, 100, 2 * OFF_TIME_SELECT_STEP_CYC);
    t_off(8'h00, 600, 2 * OFF_TIME_SELECT_STEP_CYC);
    t_off(8'h0c, 100, 4 * OFF_TIME_SELECT_STEP_CYC);
    t_blank();
    t_rdis();
    drive_brake <= 1'b1;
    pins(1'b1, 1'b0);
    check({7'h0, a_oe & a_out & b_oe}, 8'h01);
    sleep_n <= 1'b0;
    pins(1'b1, 1'b0);
    check({4'h0, seen}, 8'h00);
    results();
  end
endmodule // testbench
